// File: pkg/uab_map.svh
/*
 * Register map, field positions, reset values and counts of the auto-baud unit.
 * Assumes inclusion by bare name from any file that needs these numbers.
 */
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH

// Byte addresses on the peripheral bus
`define UAB_ADDR_CONTROL 32'hE001_0020
`define UAB_ADDR_PERMIT 32'hE001_0030

// Auto-baud control fields
`define UAB_BIT_START 0
`define UAB_BIT_MODE 1
`define UAB_BIT_RESTART 2
`define UAB_BIT_END_CLR 8
`define UAB_BIT_TO_CLR 9

// Transmit-permit field
`define UAB_BIT_PERMIT 7

// Reset values
`define UAB_RST_START 1'b0
`define UAB_RST_MODE 1'b0
`define UAB_RST_RESTART 1'b0
`define UAB_RST_PERMIT 1'b1

// Sampling pulses issued to the shifter during the start bit
`define UAB_RSR_PULSES 5'h10

// Last value of the measurement counter before overflow
`define UAB_CNT_MAX 16'hFFFF

`endif

// File: pkg/uab_pkg.sv
/*
 * Types shared by the auto-baud unit and its edge detector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package uab_pkg;
    // Stored control fields of the auto-baud control register
    typedef struct packed {
        logic restart;
        logic mode;
        logic start;
    } uab_ctrl_t;

    // Value loaded into the two divisor latches
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } uab_div_t;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        UAB_IDLE,
        UAB_ARMED,
        UAB_COUNT
    } uab_state_t;
endpackage : uab_pkg

`default_nettype wire

// File: src/uab_rx_edge.sv
/*
 * Receive-line synchroniser with falling and rising edge pulses.
 * Assumes rx_pin is asynchronous to clk; rst_n is already synchronised.
 */
`default_nettype none

module uab_rx_edge
    import uab_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_pin,
    output logic rx_level,
    output logic rx_fall,
    output logic rx_rise
);
    logic meta; // First stage, read only by the second
    logic sync; // Second stage
    logic last; // Previous synchronised level
    logic next_meta;
    logic next_sync;
    logic next_last;

    ////////////////////////////////////////////////////////////////////////
    // Next values; idle line is high
    always_comb begin
        next_meta = rx_pin;
        next_sync = meta;
        next_last = sync;
    end

    // Register stage, reset to the idle level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edges compare the two settled stages only
    assign rx_level = sync;
    assign rx_fall = last & ~sync;
    assign rx_rise = ~last & sync;
endmodule : uab_rx_edge

`default_nettype wire

// File: src/uab_top.sv
/*
 * Auto-baud measurement unit and transmit-permit gate of a serial port.
 * Assumes a peripheral bus with psel/penable phases, a fractional divider
 * that supplies frac_tick, and the rest of the port around the outputs.
 */
// Overview of operation
// - Start bit begins, abort clears, hardware clears
// - Mode 0 measures falling to falling edge
// - Mode 1 measures falling to rising edge
// - Restart bit rearms on next falling edge
// - Counter overflow is auto-baud time-out
// - Time-out flag set only when enabled
// - End flag set after divisor load, enabled
// - Writing one at bit 8 clears end
// - Writing one at bit 9 clears time-out
// - Start resets counter, shifter, fast rate
// - Falling edge starts prescaled cycle counting
// - Sixteen sampling pulses during start bit
// - Stop loads divisor, baud returns normal
// - Shifter keeps assembling the same character
// - Fractional divider untouched; zero add disables
// - Permit set keeps queued characters sending
// - Permit clear stops further transmission
// - Start bit position 0, resets zero
// - Permit bit 7 resets one, finishes character
`default_nettype none
`include "uab_map.svh"

module uab_top
    import uab_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic [3:0] frac_add_value,
    input wire logic frac_tick,
    input wire logic end_irq_enable,
    input wire logic timeout_irq_enable,
    output logic end_irq_flag,
    output logic timeout_irq_flag,
    output logic div_load,
    output var uab_div_t div_value,
    output logic rsr_reset,
    output logic rsr_fast,
    output logic rsr_sample,
    input wire logic thr_valid,
    input wire logic tsr_idle,
    output logic tsr_load,
    output logic tx_permit
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive line, synchronised with edge pulses
    logic rx_level;
    logic rx_fall;
    logic rx_rise;

    uab_rx_edge u_rx_edge (
        .clk(clk),
        .rst_n(rst_n),
        .rx_pin(rx_pin),
        .rx_level(rx_level),
        .rx_fall(rx_fall),
        .rx_rise(rx_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; writes happen in the access phase, read data is captured in the setup phase
    logic hit_ctrl; // Control register selected
    logic hit_permit; // Permit register selected
    logic wr_ctrl;
    logic wr_permit;
    logic rd_setup; // Read data captured in setup phase

    assign hit_ctrl = (paddr == `UAB_ADDR_CONTROL);
    assign hit_permit = (paddr == `UAB_ADDR_PERMIT);
    assign wr_ctrl = psel & penable & pwrite & hit_ctrl;
    assign wr_permit = psel & penable & pwrite & hit_permit;
    assign rd_setup = psel & ~penable & ~pwrite;
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_ctrl | hit_permit);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, counter, control fields and flags
    uab_state_t state;
    uab_state_t next_state;
    uab_ctrl_t ctrl;
    uab_ctrl_t next_ctrl;
    logic [15:0] count; // Measurement counter
    logic [15:0] next_count;
    logic [4:0] pulses; // Sampling pulses issued this start bit
    logic [4:0] next_pulses;
    logic next_end_flag;
    logic next_to_flag;
    logic next_div_load;
    uab_div_t next_div_value;
    logic next_rsr_reset;
    logic next_rsr_sample;
    logic permit;
    logic next_permit;
    logic [31:0] next_prdata;
    logic tick; // One counting step
    logic overflow; // Counter would pass its last value
    logic stop_edge; // Edge that ends the measurement
    logic done_ok;
    logic timeout;
    logic start_set; // Software sets start from zero

    // Zero add value disables the prescaler: count every cycle
    assign tick = (frac_add_value == 4'h0) ? 1'b1 : frac_tick;
    assign overflow = (state == UAB_COUNT) & tick & (count == `UAB_CNT_MAX);
    assign stop_edge = ctrl.mode ? rx_rise : rx_fall;
    assign done_ok = (state == UAB_COUNT) & stop_edge & ~overflow;
    // Overflow always ends the run; a stop edge in that cycle cannot leave it counting
    assign timeout = overflow;
    assign start_set = wr_ctrl & pwdata[`UAB_BIT_START] & ~ctrl.start;

    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_count = count;
        next_pulses = pulses;
        next_div_load = 1'b0;
        next_div_value = div_value;
        next_rsr_reset = 1'b0;
        next_rsr_sample = 1'b0;
        next_end_flag = end_irq_flag;
        next_to_flag = timeout_irq_flag;
        // Clears first so that a same-cycle event below wins
        if (wr_ctrl && pwdata[`UAB_BIT_END_CLR]) begin
            next_end_flag = 1'b0;
        end
        if (wr_ctrl && pwdata[`UAB_BIT_TO_CLR]) begin
            next_to_flag = 1'b0;
        end
        // Sequencer
        case (state)
            UAB_IDLE: begin
            end
            UAB_ARMED: begin
                // Falling edge marks the start bit
                if (rx_fall) begin
                    next_state = UAB_COUNT;
                    next_count = 16'h0000;
                    next_pulses = 5'h00;
                end
            end
            UAB_COUNT: begin
                if (tick) begin
                    next_count = count + 16'h0001;
                end
                // Feed the shifter while the start bit is low
                if (tick && !rx_level && pulses != `UAB_RSR_PULSES) begin
                    next_rsr_sample = 1'b1;
                    next_pulses = pulses + 5'h01;
                end
                if (done_ok) begin
                    next_div_load = 1'b1;
                    // The stop cycle's own tick counts, so the load equals the interval
                    next_div_value = tick ? count + 16'h0001 : count;
                    next_ctrl.start = 1'b0;
                    next_state = UAB_IDLE;
                    if (end_irq_enable) begin
                        next_end_flag = 1'b1;
                    end
                end else if (timeout) begin
                    if (timeout_irq_enable) begin
                        next_to_flag = 1'b1;
                    end
                    if (ctrl.restart) begin
                        next_state = UAB_ARMED;
                        next_count = 16'h0000;
                    end else begin
                        next_ctrl.start = 1'b0;
                        next_state = UAB_IDLE;
                    end
                end
            end
            default: begin
                next_state = UAB_IDLE;
            end
        endcase
        // Software write of the control register
        if (wr_ctrl) begin
            next_ctrl.mode = pwdata[`UAB_BIT_MODE];
            next_ctrl.restart = pwdata[`UAB_BIT_RESTART];
            if (start_set) begin
                // Fresh measurement: clear counter and shifter
                next_ctrl.start = 1'b1;
                next_state = UAB_ARMED;
                next_count = 16'h0000;
                next_rsr_reset = 1'b1;
            end else if (!pwdata[`UAB_BIT_START]) begin
                // Abort; a pending load in this cycle is lost by design
                next_ctrl.start = 1'b0;
                next_state = UAB_IDLE;
                next_div_load = 1'b0;
                // No load means no successful end, so its flag is not raised either
                next_end_flag = end_irq_flag & ~pwdata[`UAB_BIT_END_CLR];
            end
        end
        // Permit register write
        next_permit = permit;
        if (wr_permit) begin
            next_permit = pwdata[`UAB_BIT_PERMIT];
        end
        // Read data; reserved bits read as zero, clear bits write only
        next_prdata = prdata;
        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            if (hit_ctrl) begin
                next_prdata[`UAB_BIT_START] = ctrl.start;
                next_prdata[`UAB_BIT_MODE] = ctrl.mode;
                next_prdata[`UAB_BIT_RESTART] = ctrl.restart;
            end else if (hit_permit) begin
                next_prdata[`UAB_BIT_PERMIT] = permit;
            end
        end
    end

    // Register stage for all of the above
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= UAB_IDLE;
            ctrl <= '{restart: `UAB_RST_RESTART, mode: `UAB_RST_MODE, start: `UAB_RST_START};
            count <= 16'h0000;
            pulses <= 5'h00;
            div_load <= 1'b0;
            div_value <= 16'h0000;
            rsr_reset <= 1'b0;
            rsr_sample <= 1'b0;
            end_irq_flag <= 1'b0;
            timeout_irq_flag <= 1'b0;
            permit <= `UAB_RST_PERMIT;
            prdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            count <= next_count;
            pulses <= next_pulses;
            div_load <= next_div_load;
            div_value <= next_div_value;
            rsr_reset <= next_rsr_reset;
            rsr_sample <= next_rsr_sample;
            end_irq_flag <= next_end_flag;
            timeout_irq_flag <= next_to_flag;
            permit <= next_permit;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifter runs at its fastest rate while a measurement is pending
    assign rsr_fast = (state != UAB_IDLE);
    // Shifter is only reset at start, so the character survives the load
    // Permit gates only the hand-over into the shift register
    assign tx_permit = permit;
    assign tsr_load = permit & thr_valid & tsr_idle;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_load_clears_start: assert property (div_load |-> !ctrl.start && state == UAB_IDLE)
        else $error("start still set after divisor load");
    a_mode0_fall_stop: assert property (
        state == UAB_COUNT && !ctrl.mode && rx_fall && !overflow && !wr_ctrl
        |=> div_load && div_value == ($past(tick) ? $past(count) + 16'h0001 : $past(count)))
        else $error("mode 0 did not stop on falling edge");
    a_mode1_rise_stop: assert property (
        state == UAB_COUNT && ctrl.mode && rx_rise && !overflow && !wr_ctrl
        |=> div_load)
        else $error("mode 1 did not stop on rising edge");
    a_restart_rearm: assert property (
        timeout && ctrl.restart && !wr_ctrl |=> state == UAB_ARMED && count == 16'h0000)
        else $error("no rearm after time-out");
    a_timeout_flag_set: assert property (
        timeout && timeout_irq_enable |=> timeout_irq_flag)
        else $error("time-out flag not set");
    a_timeout_flag_cause: assert property (
        $rose(timeout_irq_flag) |-> $past(timeout) && $past(timeout_irq_enable))
        else $error("time-out flag set without cause");
    a_end_after_load: assert property (
        $rose(end_irq_flag) |-> div_load)
        else $error("end flag not with divisor load");
    a_end_clear: assert property (
        wr_ctrl && pwdata[`UAB_BIT_END_CLR] && !done_ok |=> !end_irq_flag)
        else $error("end flag not cleared");
    a_to_clear: assert property (
        wr_ctrl && pwdata[`UAB_BIT_TO_CLR] && !timeout |=> !timeout_irq_flag)
        else $error("time-out flag not cleared");
    a_start_resets: assert property (
        start_set |=> rsr_reset && count == 16'h0000 && rsr_fast)
        else $error("start did not reset counter and shifter");
    a_pulse_limit: assert property (pulses <= `UAB_RSR_PULSES)
        else $error("too many sampling pulses");
    a_permit_gate: assert property (!tx_permit |-> !tsr_load)
        else $error("load while transmit not permitted");

    c_end_ok: cover property (div_load && end_irq_flag);
    c_timeout_rearm: cover property (timeout && ctrl.restart);
    c_mode1_done: cover property (ctrl.mode && div_load);
    c_abort: cover property (state == UAB_COUNT ##1 state == UAB_IDLE && !div_load);
endmodule : uab_top

`default_nettype wire

// File: verif/uab_term_model.sv
/*
 * Remote terminal model: sends framed characters on the receive line.
 * Assumes the bench pulses go for one clk and holds ch and bit_len meanwhile.
 */
`default_nettype none

module uab_term_model (
    input wire logic clk,
    input wire logic go,
    input wire logic hold_low,
    input wire logic [7:0] ch,
    input wire logic [15:0] bit_len,
    output logic rx_pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic line; // Mark level, high between frames
    logic [9:0] frame; // Stop, data, start

    // A stuck-low sender, used to run the counter into its time-out
    assign rx_pin = hold_low ? 1'b0 : line;

    ////////////////////////////////////////////////////////////////////////////
    // One frame: start bit, eight data bits lsb first, one stop bit
    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy = 1'b1;
                frame = {1'b1, ch, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    // Off the edge, so the synchroniser latency stays fixed
                    #1 line = frame[i];
                    repeat (bit_len) @(posedge clk);
                end
                busy = 1'b0;
            end
        end
    end
endmodule : uab_term_model

`default_nettype wire

// File: verif/testbench.sv
/*
 * Self-checking bench of the auto-baud unit and transmit-permit gate.
 * Assumes the terminal model on the receive line; divisor loads are
 * compared against notes queued by the driver.
 */
`default_nettype none
`include "uab_map.svh"

module testbench
    import uab_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Expected result of one divisor load; smp below zero means not checked
    typedef struct {
        logic [15:0] div;
        logic flag;
        int smp;
    } uab_note_t;

    logic clk = 1'b0;
    logic arst_n, psel, penable, pwrite, pready, pslverr, rx_pin;
    logic frac_tick = 1'b0;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] frac_add_value;
    logic end_irq_enable, timeout_irq_enable, end_irq_flag, timeout_irq_flag;
    logic div_load, rsr_reset, rsr_fast, rsr_sample, thr_valid, tsr_idle;
    logic tsr_load, tx_permit, go, hold_low, busy, err;
    logic [7:0] ch;
    logic [15:0] bit_len;
    uab_div_t div_value;
    uab_note_t exp_q[$], n;
    int fails = 0, compares = 0, smp = 0, bl, k;

    always #10 clk = ~clk;
    // Prescaler tick every second clk; only counted when add value is nonzero
    always @(posedge clk) frac_tick <= ~frac_tick;

    uab_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .frac_add_value(frac_add_value), .frac_tick(frac_tick),
        .end_irq_enable(end_irq_enable), .timeout_irq_enable(timeout_irq_enable),
        .end_irq_flag(end_irq_flag), .timeout_irq_flag(timeout_irq_flag),
        .div_load(div_load), .div_value(div_value), .rsr_reset(rsr_reset),
        .rsr_fast(rsr_fast), .rsr_sample(rsr_sample), .thr_valid(thr_valid),
        .tsr_idle(tsr_idle), .tsr_load(tsr_load), .tx_permit(tx_permit));

    uab_term_model term_u (.clk(clk), .go(go), .hold_low(hold_low), .ch(ch),
        .bit_len(bit_len), .rx_pin(rx_pin), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    // One bounded clk of waiting; running out ends the run
    task automatic tick(input int lim);
        @(posedge clk);
        #1 k++;
        if (k >= lim) begin
            check(1'b0, "wait bound used up");
            print_verdict();
        end
    endtask : tick

    // Setup then access phase; answer taken at the edge closing access
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(posedge clk);
        #1 penable = 1'b1;
        @(posedge clk);
        rd = prdata;
        err = pslverr;
        #1 psel = 1'b0;
        penable = 1'b0;
    endtask : bus

    task automatic send();
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        k = 0;
        while (busy) tick(5000);
    endtask : send

    // Arm with ctl, send one character, expect one load
    task automatic measure(input logic [31:0] ctl, input int div, input logic f,
                           input int s);
        exp_q.push_back('{16'(div), f, s});
        bus(1'b1, `UAB_ADDR_CONTROL, ctl);
        check(rsr_fast === 1'b1 && rsr_reset === 1'(s >= 0), "shifter not reset or fast");
        send();
        k = 0;
        while (exp_q.size() != 0) tick(100);
        check(rsr_fast === 1'b0, "shifter still fast");
        bus(1'b0, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(rd[0] === 1'b0, "start not cleared");
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: each divisor load takes the oldest note
    always @(posedge clk) begin
        if (rsr_reset === 1'b1) begin
            smp = 0;
        end else if (rsr_sample === 1'b1) begin
            smp++;
        end
        if (div_load === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "unexpected divisor load");
            end else begin
                n = exp_q.pop_front();
                check(div_value === n.div, "divisor value");
                check(end_irq_flag === n.flag, "end flag");
                if (n.smp >= 0) check(smp == n.smp, "sample pulses");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(4));
        {arst_n, psel, penable, pwrite, go, hold_low} = '0;
        {thr_valid, tsr_idle, end_irq_enable, timeout_irq_enable} = '0;
        paddr = '0;
        pwdata = '0;
        frac_add_value = 4'h0;
        ch = 8'h41;
        bl = 20 + 2 * ($urandom % 10);
        bit_len = 16'(bl);
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(rd[2:0] === 3'h0, "control reset value");
        bus(1'b0, `UAB_ADDR_PERMIT, 32'h0000_0000);
        check(rd[7] === 1'b1 && tx_permit === 1'b1, "permit reset value");
        bus(1'b0, 32'hE001_0024, 32'h0000_0000);
        check(err === 1'b1 && pready === 1'b1 && rd === 32'h0000_0000, "unmapped access");
        $display("test reset done");
        measure(32'h0000_0001, 2 * bl, 1'b0, 16);
        end_irq_enable = 1'b1;
        measure(32'h0000_0003, bl, 1'b1, 16);
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(end_irq_flag === 1'b1, "end flag cleared by zero");
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0100);
        check(end_irq_flag === 1'b0, "end flag not cleared");
        frac_add_value = 4'h1;
        ch = 8'h61;
        // Start bit twice as long, so sixteen prescaled pulses still fit inside it
        bit_len = 16'(2 * bl);
        measure(32'h0000_0003, bl, 1'b1, 16);
        bit_len = 16'(bl);
        frac_add_value = 4'h0;
        $display("test measure done");
        // Abort: a char after clearing start must not load
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0001);
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0000);
        bus(1'b0, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(rd[0] === 1'b0, "abort left start set");
        send();
        repeat (8) @(posedge clk);
        $display("test abort done");
        // Stuck-low line overflows the counter; restart re-arms
        timeout_irq_enable = 1'b1;
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0007);
        hold_low = 1'b1;
        k = 0;
        while (timeout_irq_flag !== 1'b1) tick(70000);
        check(k > 65536, "time-out too early");
        hold_low = 1'b0;
        bus(1'b0, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(rd[0] === 1'b1, "no restart after time-out");
        measure(32'h0000_0007, bl, 1'b1, -1);
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0000);
        check(timeout_irq_flag === 1'b1, "time-out flag cleared by zero");
        bus(1'b1, `UAB_ADDR_CONTROL, 32'h0000_0200);
        check(timeout_irq_flag === 1'b0, "time-out flag not cleared");
        $display("test timeout done");
        // Transmit gate with random holding and shifter states
        for (int p = 1; p >= 0; p--) begin
            bus(1'b1, `UAB_ADDR_PERMIT, {24'h00_0000, 1'(p), 7'h00});
            check(tx_permit === 1'(p), "permit bit");
            repeat (8) begin
                @(posedge clk);
                #1 thr_valid = 1'($urandom);
                tsr_idle = 1'($urandom);
                @(negedge clk);
                check(tsr_load === (1'(p) & thr_valid & tsr_idle), "shifter load");
            end
        end
        $display("test gate done");
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
